// File: hdl/pdps_defines.svh
`ifndef PDPS_DEFINES_SVH
`define PDPS_DEFINES_SVH

// register byte offsets on the apb bus
`define PDPS_OFS_LOWER  12'h000
`define PDPS_OFS_UPPER  12'h004
`define PDPS_OFS_HIGH1  12'h008
`define PDPS_OFS_HIGH2  12'h00c
`define PDPS_OFS_DIR    12'h010
`define PDPS_OFS_STATUS 12'h014

// pins handled here: 10 up to 15, index 0 is pin 10
`define PDPS_FIRST_PIN  10
`define PDPS_LAST_PIN   15
`define PDPS_UPPER_LSB  8

// reset values
`define PDPS_LOWER_RST  16'h0000
`define PDPS_UPPER_RST  8'h00
`define PDPS_DIR_RST    6'h00

// pins 12 and 13 are input only in trace mode
`define PDPS_IN_ONLY    6'h0c

// status register fields
`define PDPS_STAT_BAD_LSB 0
`define PDPS_STAT_OE_LSB  8

`endif

// File: hdl/pdps_pkg.sv
`default_nettype none

package pdps_pkg;

    typedef enum logic [1:0] {
        pdps_mode_port  = 2'b00,
        pdps_mode_bus   = 2'b01,
        pdps_mode_trace = 2'b10,
        pdps_mode_bad   = 2'b11
    } pdps_mode_t;

    typedef enum logic [2:0] {
        pdps_reg_lower  = 3'b000,
        pdps_reg_upper  = 3'b001,
        pdps_reg_high1  = 3'b010,
        pdps_reg_high2  = 3'b011,
        pdps_reg_dir    = 3'b100,
        pdps_reg_status = 3'b101,
        pdps_reg_none   = 3'b111
    } pdps_reg_t;

endpackage

`default_nettype wire

// File: hdl/pdps_reg_if.sv
`default_nettype none

interface pdps_reg_if;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic [31:0] rdata;
    logic        hit;

    modport slave (output addr, output wdata, output wr, input rdata, input hit);
    modport regs  (input addr, input wdata, input wr, output rdata, output hit);
endinterface

`default_nettype wire

// File: hdl/pdps_apb_slave.sv
`default_nettype none

module pdps_apb_slave (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // register side
    pdps_reg_if.slave        rif
);

    logic setup_w;

    assign setup_w   = psel & ~penable;
    assign rif.addr  = paddr;
    assign rif.wdata = pwdata;
    // write lands only at the edge that completes the access
    assign rif.wr    = psel & penable & pready & pwrite & rif.hit;

    // one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_w;
        end
    end

    // read data caught in setup, stands until the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_w) begin
            prdata <= (rif.hit & ~pwrite) ? rif.rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_w & ~rif.hit;
        end
    end

endmodule

`default_nettype wire

// File: hdl/pdps_pin_mux.sv
`default_nettype none
`include "pdps_defines.svh"

module pdps_pin_mux (
    // selection
    input  wire logic [5:0][1:0] mode,
    input  wire logic [5:0]      dir,
    // pads
    input  wire logic [5:0]      pad_in,
    output var  logic [5:0]      pad_out_d,
    output var  logic [5:0]      pad_oe_d,
    // general port
    input  wire logic [5:0]      gpio_out,
    output var  logic [5:0]      gpio_in_d,
    // bus controller data
    input  wire logic [5:0]      bus_dout,
    input  wire logic            bus_doe,
    output var  logic [5:0]      bus_din_d,
    // debug trace port
    input  wire logic [5:0]      trace_out,
    input  wire logic [5:0]      trace_oe,
    output var  logic [5:0]      trace_in_d
);

    localparam logic [5:0] IN_ONLY = `PDPS_IN_ONLY;

    for (genvar i = 0; i < 6; i++) begin : g_pin
        // consumers not selected see zero, not the pad
        always_comb begin
            pad_out_d[i]  = 1'b0;
            pad_oe_d[i]   = 1'b0;
            gpio_in_d[i]  = 1'b0;
            bus_din_d[i]  = 1'b0;
            trace_in_d[i] = 1'b0;
            case (pdps_pkg::pdps_mode_t'(mode[i]))
                pdps_pkg::pdps_mode_port: begin
                    pad_out_d[i] = gpio_out[i];
                    pad_oe_d[i]  = dir[i];
                    gpio_in_d[i] = pad_in[i];
                end
                pdps_pkg::pdps_mode_bus: begin
                    pad_out_d[i] = bus_dout[i];
                    pad_oe_d[i]  = bus_doe;
                    bus_din_d[i] = pad_in[i];
                end
                pdps_pkg::pdps_mode_trace: begin
                    pad_out_d[i]  = trace_out[i] & ~IN_ONLY[i];
                    pad_oe_d[i]   = trace_oe[i] & ~IN_ONLY[i];
                    trace_in_d[i] = pad_in[i];
                end
                // prohibited code: pin left floating, nobody listens
                default: begin
                    pad_oe_d[i] = 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// File: hdl/pdps_top.sv
// Operation
// - four 16-bit port d control registers
// - high registers, upper low byte read zero
// - pin mode is upper-register bit, lower-register bit
// - upper mode bits reset zero, read/write
// - pin 15: port, bus d15, trace sync
// - pin 14: port, bus d14, trace clock
// - pin 13: port, bus d13, trace mode input
// - pin 12: port, bus d12, trace reset input
// - pin 11: port, bus d11, trace data 3
// - pin 10: port, bus d10, trace data 2
// - port mode: direction bit sets output
`default_nettype none
`include "pdps_defines.svh"

module pdps_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // pads, index 0 is pin 10
    input  wire logic [5:0]  pad_in,
    output var  logic [5:0]  pad_out,
    output var  logic [5:0]  pad_oe,
    // general port
    input  wire logic [5:0]  gpio_out,
    output var  logic [5:0]  gpio_in,
    // bus controller data bits 15 to 10
    input  wire logic [5:0]  bus_dout,
    input  wire logic        bus_doe,
    output var  logic [5:0]  bus_din,
    // debug trace port
    input  wire logic [5:0]  trace_out,
    input  wire logic [5:0]  trace_oe,
    output var  logic [5:0]  trace_in
);

    function automatic pdps_pkg::pdps_reg_t reg_decode(input logic [11:0] a);
        case (a)
            `PDPS_OFS_LOWER:  reg_decode = pdps_pkg::pdps_reg_lower;
            `PDPS_OFS_UPPER:  reg_decode = pdps_pkg::pdps_reg_upper;
            `PDPS_OFS_HIGH1:  reg_decode = pdps_pkg::pdps_reg_high1;
            `PDPS_OFS_HIGH2:  reg_decode = pdps_pkg::pdps_reg_high2;
            `PDPS_OFS_DIR:    reg_decode = pdps_pkg::pdps_reg_dir;
            `PDPS_OFS_STATUS: reg_decode = pdps_pkg::pdps_reg_status;
            default:          reg_decode = pdps_pkg::pdps_reg_none;
        endcase
    endfunction

    pdps_reg_if rif ();

    pdps_pkg::pdps_reg_t sel_w;
    logic [15:0]         lower_q;
    logic [15:8]         upper_q;
    logic [5:0]          dir_q;
    logic [5:0][1:0]     mode_w;
    logic [5:0]          bad_w;
    logic [5:0]          pad_out_d;
    logic [5:0]          pad_oe_d;
    logic [5:0]          gpio_in_d;
    logic [5:0]          bus_din_d;
    logic [5:0]          trace_in_d;

    pdps_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rif     (rif.slave)
    );

    assign sel_w   = reg_decode(rif.addr);
    assign rif.hit = (sel_w != pdps_pkg::pdps_reg_none);

    // lower mode bits, all sixteen kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_q <= `PDPS_LOWER_RST;
        end else if (rif.wr && sel_w == pdps_pkg::pdps_reg_lower) begin
            lower_q <= rif.wdata[15:0];
        end
    end

    // low byte has no storage so it can never read back non-zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_q <= `PDPS_UPPER_RST;
        end else if (rif.wr && sel_w == pdps_pkg::pdps_reg_upper) begin
            upper_q <= rif.wdata[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= `PDPS_DIR_RST;
        end else if (rif.wr && sel_w == pdps_pkg::pdps_reg_dir) begin
            dir_q <= rif.wdata[`PDPS_LAST_PIN:`PDPS_FIRST_PIN];
        end
    end

    // mode field per pin from the two low registers
    for (genvar i = 0; i < 6; i++) begin : g_mode
        assign mode_w[i] = {upper_q[`PDPS_FIRST_PIN + i], lower_q[`PDPS_FIRST_PIN + i]};
        assign bad_w[i]  = (mode_w[i] == pdps_pkg::pdps_mode_bad);
    end

    // high registers and reserved bits: no storage, read zero
    always_comb begin
        rif.rdata = 32'h0000_0000;
        case (sel_w)
            pdps_pkg::pdps_reg_lower: rif.rdata[15:0]  = lower_q;
            pdps_pkg::pdps_reg_upper: rif.rdata[15:8]  = upper_q;
            pdps_pkg::pdps_reg_dir:   rif.rdata[15:10] = dir_q;
            pdps_pkg::pdps_reg_status: begin
                rif.rdata[`PDPS_STAT_BAD_LSB +: 6] = bad_w;
                rif.rdata[`PDPS_STAT_OE_LSB +: 6]  = pad_oe;
            end
            default:                  rif.rdata = 32'h0000_0000;
        endcase
    end

    pdps_pin_mux u_mux (
        .mode       (mode_w),
        .dir        (dir_q),
        .pad_in     (pad_in),
        .pad_out_d  (pad_out_d),
        .pad_oe_d   (pad_oe_d),
        .gpio_out   (gpio_out),
        .gpio_in_d  (gpio_in_d),
        .bus_dout   (bus_dout),
        .bus_doe    (bus_doe),
        .bus_din_d  (bus_din_d),
        .trace_out  (trace_out),
        .trace_oe   (trace_oe),
        .trace_in_d (trace_in_d)
    );

    // every path through the mux costs one cycle, traded for clean outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 6'h00;
            pad_oe  <= 6'h00;
        end else begin
            pad_out <= pad_out_d;
            pad_oe  <= pad_oe_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_in  <= 6'h00;
            bus_din  <= 6'h00;
            trace_in <= 6'h00;
        end else begin
            gpio_in  <= gpio_in_d;
            bus_din  <= bus_din_d;
            trace_in <= trace_in_d;
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic       wr_lower_w;
    logic       wr_upper_w;
    logic       wr_high_w;
    logic [5:0] port_mask_w;

    assign wr_lower_w = rif.wr && sel_w == pdps_pkg::pdps_reg_lower;
    assign wr_upper_w = rif.wr && sel_w == pdps_pkg::pdps_reg_upper;
    assign wr_high_w  = rif.wr && (sel_w == pdps_pkg::pdps_reg_high1
                                   || sel_w == pdps_pkg::pdps_reg_high2);
    for (genvar i = 0; i < 6; i++) begin : g_pmask
        assign port_mask_w[i] = (mode_w[i] == pdps_pkg::pdps_mode_port);
    end

    chk_lower_write_read: assert property (
        (psel && !penable && !pwrite && paddr == `PDPS_OFS_LOWER)
        |=> (pready && prdata == {16'h0000, $past(lower_q)})
    ) else $error("lower register read back wrong");

    chk_high_read_zero: assert property (
        (psel && !penable && !pwrite
         && (paddr == `PDPS_OFS_HIGH1 || paddr == `PDPS_OFS_HIGH2))
        |=> (pready && !pslverr && prdata == 32'h0000_0000)
    ) else $error("high register read not zero");

    chk_upper_low_zero: assert property (
        (psel && !penable && !pwrite && paddr == `PDPS_OFS_UPPER)
        |=> (prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000)
    ) else $error("reserved low byte of upper register not zero");

    chk_mode_pair: assert property (
        wr_upper_w
        |=> (mode_w[5] == {$past(pwdata[15]), $past(lower_q[15])}
             && mode_w[0] == {$past(pwdata[10]), $past(lower_q[10])})
    ) else $error("mode field not formed from the two registers");

    chk_upper_write: assert property (
        wr_upper_w |=> (upper_q == $past(pwdata[15:8]))
    ) else $error("upper mode bits did not take the write");

    chk_pin15_trace: assert property (
        (mode_w[5] == pdps_pkg::pdps_mode_trace)
        |=> (pad_out[5] == $past(trace_out[5]) && pad_oe[5] == $past(trace_oe[5]))
    ) else $error("pin 15 not routed to trace sync");

    chk_pin14_bus: assert property (
        (mode_w[4] == pdps_pkg::pdps_mode_bus)
        |=> (pad_out[4] == $past(bus_dout[4]) && pad_oe[4] == $past(bus_doe)
             && bus_din[4] == $past(pad_in[4]))
    ) else $error("pin 14 not routed to data bus");

    chk_pin13_input: assert property (
        (mode_w[3] == pdps_pkg::pdps_mode_trace)
        |=> (!pad_oe[3] && trace_in[3] == $past(pad_in[3]))
    ) else $error("pin 13 drives in trace mode");

    chk_pin12_input: assert property (
        (mode_w[2] == pdps_pkg::pdps_mode_trace && trace_oe[2])
        |=> (!pad_oe[2] && !gpio_in[2] && !bus_din[2])
    ) else $error("pin 12 drives in trace mode");

    chk_pin11_trace: assert property (
        (mode_w[1] == pdps_pkg::pdps_mode_trace)
        |=> (pad_oe[1] == $past(trace_oe[1]) && trace_in[1] == $past(pad_in[1]))
    ) else $error("pin 11 not routed to trace data 3");

    chk_pin10_bad: assert property (
        (mode_w[0] == pdps_pkg::pdps_mode_bad)
        |=> (!pad_oe[0] && !gpio_in[0] && !bus_din[0] && !trace_in[0])
    ) else $error("pin 10 prohibited code drives the pad");

    chk_port_dir: assert property (
        1'b1 |=> ((pad_oe & $past(port_mask_w)) == ($past(dir_q) & $past(port_mask_w)))
    ) else $error("port direction not applied");

    chk_reserved_write: assert property (
        wr_high_w |=> ($stable(lower_q) && $stable(upper_q) && $stable(dir_q))
    ) else $error("reserved register write changed state");

    chk_lower_write: assert property (
        wr_lower_w |=> (lower_q == $past(pwdata[15:0]))
    ) else $error("lower mode bits did not take the write");

    chk_ready_single: assert property (
        pready |=> !pready
    ) else $error("ready held for more than one cycle");

    chk_status_bad: assert property (
        (psel && !penable && !pwrite && paddr == `PDPS_OFS_STATUS)
        |=> (prdata[5:0] == $past(bad_w) && prdata[13:8] == $past(pad_oe))
    ) else $error("status register does not show mode state");

    chk_pin15_bus: assert property (
        (mode_w[5] == pdps_pkg::pdps_mode_bus)
        |=> (pad_out[5] == $past(bus_dout[5]) && bus_din[5] == $past(pad_in[5]))
    ) else $error("pin 15 not routed to data bus");

    chk_pin14_trace: assert property (
        (mode_w[4] == pdps_pkg::pdps_mode_trace)
        |=> (pad_out[4] == $past(trace_out[4]) && pad_oe[4] == $past(trace_oe[4]))
    ) else $error("pin 14 not routed to trace clock");

    chk_pin13_bus: assert property (
        (mode_w[3] == pdps_pkg::pdps_mode_bus)
        |=> (pad_oe[3] == $past(bus_doe) && bus_din[3] == $past(pad_in[3]))
    ) else $error("pin 13 not routed to data bus");

    chk_pin12_trace: assert property (
        (mode_w[2] == pdps_pkg::pdps_mode_trace)
        |=> (trace_in[2] == $past(pad_in[2]) && !pad_out[2])
    ) else $error("pin 12 trace reset input not passed on");

    chk_pin11_bus: assert property (
        (mode_w[1] == pdps_pkg::pdps_mode_bus)
        |=> (pad_out[1] == $past(bus_dout[1]) && !trace_in[1])
    ) else $error("pin 11 not routed to data bus");

    chk_pin10_trace: assert property (
        (mode_w[0] == pdps_pkg::pdps_mode_trace)
        |=> (pad_out[0] == $past(trace_out[0]) && trace_in[0] == $past(pad_in[0]))
    ) else $error("pin 10 not routed to trace data 2");

endmodule

`default_nettype wire

// File: dv/pdps_pad_model.sv
`default_nettype none

module pdps_pad_model (
    // pads seen from the board
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe,
    // what the outside world drives onto a released pin
    input  wire logic [5:0] ext_val,
    output var  logic [5:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // a released pin shows the outside level, never the last driven value
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule

`default_nettype wire

// File: dv/pdps_top_tb.sv
`default_nettype none
`include "pdps_defines.svh"

module pdps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pad_in;
    logic [5:0]  pad_out;
    logic [5:0]  pad_oe;
    logic [5:0]  gpio_out;
    logic [5:0]  gpio_in;
    logic [5:0]  bus_dout;
    logic        bus_doe;
    logic [5:0]  bus_din;
    logic [5:0]  trace_out;
    logic [5:0]  trace_oe;
    logic [5:0]  trace_in;
    logic [5:0]  ext_val;
    logic [5:0]  dir;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          samples_checked;
    int          cycles;
    logic [15:0] lo_tab [5] = '{16'h0000, 16'hfc00, 16'h0000, 16'hfc00, 16'h5400};
    logic [15:0] up_tab [5] = '{16'h0000, 16'h0000, 16'hfc00, 16'hfc00, 16'h9800};

    pdps_top u_pdps_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .gpio_out(gpio_out), .gpio_in(gpio_in),
        .bus_dout(bus_dout), .bus_doe(bus_doe), .bus_din(bus_din),
        .trace_out(trace_out), .trace_oe(trace_oe), .trace_in(trace_in)
    );

    pdps_pad_model u_pdps_pad_model (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .pad_in(pad_in)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hung handshake must not stall the run forever
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    // expected pad and consumer values worked out from the mode fields
    task automatic pins_chk(input logic [15:0] lo, input logic [15:0] up);
        logic [1:0] m;
        logic [5:0] eoe, eout, pin, gi, bi, ti, bad;
        for (int i = 0; i < 6; i++) begin
            m = {up[10+i], lo[10+i]};
            eoe[i] = 1'b0;
            eout[i] = 1'b0;
            case (m)
                2'b00: begin eoe[i] = dir[i]; eout[i] = gpio_out[i]; end
                2'b01: begin eoe[i] = bus_doe; eout[i] = bus_dout[i]; end
                2'b10: begin eoe[i] = trace_oe[i] & (i != 2) & (i != 3); eout[i] = trace_out[i]; end
                default: ;
            endcase
            pin[i] = eoe[i] ? eout[i] : ext_val[i];
            gi[i] = (m == 2'b00) & pin[i];
            bi[i] = (m == 2'b01) & pin[i];
            ti[i] = (m == 2'b10) & pin[i];
            bad[i] = (m == 2'b11);
        end
        repeat (3) @(posedge pclk);
        #1;
        check("pad_oe", {26'h0, pad_oe}, {26'h0, eoe});
        check("pad_out", {26'h0, pad_out & pad_oe}, {26'h0, eout & eoe});
        check("gpio_in", {26'h0, gpio_in}, {26'h0, gi});
        check("bus_din", {26'h0, bus_din}, {26'h0, bi});
        check("trace_in", {26'h0, trace_in}, {26'h0, ti});
        rd_chk("status", `PDPS_OFS_STATUS, {18'h0, eoe, 2'b00, bad});
    endtask

    initial begin
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        gpio_out = 6'h00;
        bus_dout = 6'h00;
        bus_doe = 1'b0;
        trace_out = 6'h00;
        trace_oe = 6'h00;
        ext_val = 6'h00;
        dir = 6'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("lower rst", `PDPS_OFS_LOWER, 32'h0000_0000);
        rd_chk("upper rst", `PDPS_OFS_UPPER, 32'h0000_0000);
        rd_chk("high1 rst", `PDPS_OFS_HIGH1, 32'h0000_0000);
        rd_chk("high2 rst", `PDPS_OFS_HIGH2, 32'h0000_0000);
        // reserved bits written with ones on purpose
        apb(1'b1, `PDPS_OFS_HIGH1, 32'hffff_ffff);
        apb(1'b1, `PDPS_OFS_HIGH2, 32'hffff_ffff);
        apb(1'b1, `PDPS_OFS_UPPER, 32'h0000_ffff);
        apb(1'b1, `PDPS_OFS_LOWER, 32'h0000_ffff);
        rd_chk("lower rw", `PDPS_OFS_LOWER, 32'h0000_ffff);
        rd_chk("upper rw", `PDPS_OFS_UPPER, 32'h0000_ff00);
        rd_chk("high1 rsvd", `PDPS_OFS_HIGH1, 32'h0000_0000);
        rd_chk("high2 rsvd", `PDPS_OFS_HIGH2, 32'h0000_0000);
        rd_chk("unmapped", 12'h020, 32'h0000_0000);
        check("pslverr", {31'h0, err}, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            dir = p ? 6'h00 : 6'h3f;
            apb(1'b1, `PDPS_OFS_DIR, {16'h0, dir, 10'h000});
            rd_chk("dir", `PDPS_OFS_DIR, {16'h0, dir, 10'h000});
            @(posedge pclk);
            gpio_out  <= p ? 6'h15 : 6'h2a;
            bus_dout  <= p ? 6'h2a : 6'h15;
            bus_doe   <= p ? 1'b0 : 1'b1;
            trace_out <= p ? 6'h0c : 6'h33;
            trace_oe  <= p ? 6'h00 : 6'h3f;
            ext_val   <= p ? 6'h30 : 6'h0f;
            for (int t = 0; t < 5; t++) begin
                apb(1'b1, `PDPS_OFS_LOWER, {16'h0, lo_tab[t]});
                apb(1'b1, `PDPS_OFS_UPPER, {16'h0, up_tab[t]});
                pins_chk(lo_tab[t], up_tab[t]);
                // reserved high registers must not disturb the pins
                apb(1'b1, `PDPS_OFS_HIGH1, 32'h0000_ffff);
                pins_chk(lo_tab[t], up_tab[t]);
            end
        end
        final_report();
    end
endmodule

`default_nettype wire
